// ===== design/urm_top.sv
/*
 * Measurement sequencing and output modes of the ultrasonic range block.
 * Assumes the analog front end gives a synchronous echo_detect level and
 * that straps are stable when reset is released.
 */
`timescale 1ns/1ps
module urm_top #(
    parameter int AUTO_CYC = urm_pkg::AUTO_PERIOD_CYC,
    parameter int SLOW_CYC = urm_pkg::SLOW_PERIOD_CYC,
    parameter int TIMEOUT_CYC = urm_pkg::TIMEOUT_CYC,
    parameter int LED_HALF_CYC = urm_pkg::LED_HALF_CYC,
    parameter int BIT_CYC = urm_pkg::BIT_CYC,
    parameter int BURST_HALF_CYC = urm_pkg::BURST_HALF_CYC,
    parameter int CYC_PER_MM = urm_pkg::CYC_PER_MM
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Mode straps
    input wire logic [2:0] strap_code,
    input wire logic auto_serial_strap,
    input wire logic polled_serial_strap,
    // Host pins
    input wire logic trig_rx,
    output logic echo_tx,
    output logic led,
    // Transducer and housekeeping
    output logic burst_drive,
    input wire logic echo_detect,
    output logic watchdog_en
);
    import urm_pkg::*;

    function automatic logic [7:0] frame_checksum(input logic [15:0] d);
        frame_checksum = 8'(FRAME_HEADER + d[15:8] + d[7:0]);
    endfunction

    function automatic logic [7:0] frame_byte(input logic [1:0] idx,
                                              input logic [15:0] d);
        case (idx)
            2'h0: frame_byte = FRAME_HEADER;
            2'h1: frame_byte = d[15:8];
            2'h2: frame_byte = d[7:0];
            default: frame_byte = frame_checksum(d);
        endcase
    endfunction

    // ------------------------------------------------------------
    // Strap capture after reset release
    // ------------------------------------------------------------
    urm_mode_t mode_q, mode_d;
    logic taken_q;

    always_comb begin
        mode_d = mode_q;
        if (!taken_q) begin
            if (auto_serial_strap) begin
                mode_d = MODE_AUTO_SER;
            end else if (polled_serial_strap) begin
                mode_d = MODE_POLL_SER;
            end else if (strap_code <= 3'h5) begin
                mode_d = urm_mode_t'(strap_code);
            end else begin
                mode_d = MODE_TRIG;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= MODE_TRIG;
            taken_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            taken_q <= 1'b1;
        end
    end

    logic serial, pulse_trig, auto_mode;
    assign serial = taken_q && (mode_q == MODE_AUTO_SER || mode_q == MODE_POLL_SER);
    assign pulse_trig = taken_q && (mode_q == MODE_TRIG || mode_q == MODE_LOWPWR);
    assign auto_mode = taken_q && (mode_q == MODE_AUTO_SER || mode_q == MODE_AUTO_PW ||
                                   mode_q == MODE_SWITCH);

    // ------------------------------------------------------------
    // Start sources: trigger pulse, period tick, serial command
    // ------------------------------------------------------------
    logic [15:0] trig_hi_q, trig_hi_d;
    logic [31:0] per_q, per_d, per_lim;
    logic tick, trig_fire, cmd_ok, start, idle, rx_valid;
    logic [7:0] rx_data;
    urm_meas_t state_q, state_d;

    assign idle = state_q == MS_IDLE;
    assign per_lim = (mode_q == MODE_AUTO_SER) ? 32'(AUTO_CYC) : 32'(SLOW_CYC);
    assign tick = auto_mode && per_q == per_lim - 32'h1;
    // Measurement begins on the falling edge of a long enough trigger
    assign trig_fire = pulse_trig && !trig_rx &&
                       trig_hi_q >= 16'(TRIG_MIN_CYC);
    // Commands during a measurement are dropped; host spacing avoids this
    assign cmd_ok = taken_q && mode_q == MODE_POLL_SER && rx_valid &&
                    rx_data == CMD_MEASURE && idle;

    always_comb begin
        trig_hi_d = trig_rx ? ((trig_hi_q == 16'hffff) ? trig_hi_q : trig_hi_q + 16'h1)
                            : 16'h0;
        per_d = (!auto_mode || tick) ? 32'h0 : per_q + 32'h1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trig_hi_q <= 16'h0;
            per_q <= 32'h0;
        end else begin
            trig_hi_q <= trig_hi_d;
            per_q <= per_d;
        end
    end

    // ------------------------------------------------------------
    // Measurement sequencer
    // ------------------------------------------------------------
    logic [31:0] meas_cnt_q, meas_cnt_d;
    logic [15:0] div_q, div_d, mm_q, mm_d, dist_q, dist_d;
    logic [15:0] hc_q, hc_d;
    logic [4:0] half_q, half_d;
    logic fr_busy_q, fr_busy_d;

    assign start = idle && !fr_busy_q && (trig_fire || tick || cmd_ok);

    always_comb begin
        state_d = state_q;
        meas_cnt_d = meas_cnt_q;
        div_d = div_q;
        mm_d = mm_q;
        hc_d = hc_q;
        half_d = half_q;
        dist_d = dist_q;
        if (state_q == MS_BURST || state_q == MS_LISTEN) begin
            // Round trip time counted from the start of emission
            meas_cnt_d = meas_cnt_q + 32'h1;
            if (div_q == 16'(CYC_PER_MM - 1)) begin
                div_d = 16'h0;
                mm_d = (mm_q == 16'hffff) ? mm_q : mm_q + 16'h1;
            end else begin
                div_d = div_q + 16'h1;
            end
        end
        case (state_q)
            MS_IDLE: begin
                if (start) begin
                    state_d = MS_BURST;
                    meas_cnt_d = 32'h0;
                    div_d = 16'h0;
                    mm_d = 16'h0;
                    hc_d = 16'h0;
                    half_d = 5'h0;
                end
            end
            MS_BURST: begin
                if (hc_q == 16'(BURST_HALF_CYC - 1)) begin
                    hc_d = 16'h0;
                    if (half_q == 5'(2 * BURST_CYCLES - 1)) begin
                        state_d = MS_LISTEN;
                    end else begin
                        half_d = half_q + 5'h1;
                    end
                end else begin
                    hc_d = hc_q + 16'h1;
                end
            end
            MS_LISTEN: begin
                if (echo_detect) begin
                    state_d = MS_REPORT;
                    dist_d = (mm_q < MIN_MM) ? MIN_MM : mm_q;
                end else if (meas_cnt_q >= 32'(TIMEOUT_CYC - 1)) begin
                    state_d = MS_REPORT;
                    dist_d = 16'h0;
                end
            end
            MS_REPORT: state_d = MS_IDLE;
            default: state_d = MS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= MS_IDLE;
            meas_cnt_q <= 32'h0;
            div_q <= 16'h0;
            mm_q <= 16'h0;
            hc_q <= 16'h0;
            half_q <= 5'h0;
            dist_q <= 16'h0;
        end else begin
            state_q <= state_d;
            meas_cnt_q <= meas_cnt_d;
            div_q <= div_d;
            mm_q <= mm_d;
            hc_q <= hc_d;
            half_q <= half_d;
            dist_q <= dist_d;
        end
    end

    logic done, echo_pulse;
    assign done = state_q == MS_REPORT;
    assign echo_pulse = state_q == MS_BURST || state_q == MS_LISTEN;

    // ------------------------------------------------------------
    // Distance frame sender
    // ------------------------------------------------------------
    logic [1:0] fr_idx_q, fr_idx_d;
    logic [15:0] fr_dist_q, fr_dist_d;
    logic tx_valid, tx_ready, txd;
    logic [7:0] tx_data;

    assign tx_valid = fr_busy_q;
    assign tx_data = frame_byte(fr_idx_q, fr_dist_q);

    always_comb begin
        fr_busy_d = fr_busy_q;
        fr_idx_d = fr_idx_q;
        fr_dist_d = fr_dist_q;
        if (done && serial) begin
            fr_busy_d = 1'b1;
            fr_idx_d = 2'h0;
            fr_dist_d = dist_q;
        end else if (fr_busy_q && tx_ready) begin
            // Next byte is offered at once, nothing else interleaves
            if (fr_idx_q == FRAME_LAST) begin
                fr_busy_d = 1'b0;
            end else begin
                fr_idx_d = fr_idx_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fr_busy_q <= 1'b0;
            fr_idx_q <= 2'h0;
            fr_dist_q <= 16'h0;
        end else begin
            fr_busy_q <= fr_busy_d;
            fr_idx_q <= fr_idx_d;
            fr_dist_q <= fr_dist_d;
        end
    end

    urm_uart #(
        .BIT_CYC(BIT_CYC)
    ) u_uart (
        .clk(clk),
        .rstn(rstn),
        .tx_valid(tx_valid),
        .tx_ready(tx_ready),
        .tx_data(tx_data),
        .txd(txd),
        .rxd(trig_rx),
        .rx_valid(rx_valid),
        .rx_data(rx_data)
    );

    // ------------------------------------------------------------
    // Switch decision, LED and pin outputs
    // ------------------------------------------------------------
    logic below, prev_below_q, prev_below_d, sw_q, sw_d;
    logic led_q, led_d, echo_q, echo_d, burst_q, burst_d, wdog_q, wdog_d;
    logic [31:0] led_cnt_q, led_cnt_d;

    assign below = dist_q != 16'h0 && dist_q < THRESH_MM;

    always_comb begin
        prev_below_d = prev_below_q;
        sw_d = sw_q;
        if (done && mode_q == MODE_SWITCH) begin
            prev_below_d = below;
            if (below && prev_below_q) begin
                sw_d = 1'b1;
            end else if (!below && dist_q != THRESH_MM) begin
                sw_d = 1'b0;
            end
        end
        led_d = led_q;
        led_cnt_d = 32'h0;
        if (taken_q && mode_q == MODE_AUTO_SER) begin
            if (led_cnt_q == 32'(LED_HALF_CYC - 1)) begin
                led_d = !led_q;
            end else begin
                led_cnt_d = led_cnt_q + 32'h1;
            end
        end else if (cmd_ok || (pulse_trig && start)) begin
            led_d = !led_q;
        end
        if (serial) begin
            echo_d = txd;
        end else if (taken_q && mode_q == MODE_SWITCH) begin
            echo_d = sw_d;
        end else begin
            echo_d = echo_pulse;
        end
        burst_d = state_q == MS_BURST && !half_q[0];
        wdog_d = !(taken_q && mode_q == MODE_LOWPWR);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_below_q <= 1'b0;
            sw_q <= 1'b0;
            led_q <= 1'b0;
            led_cnt_q <= 32'h0;
            echo_q <= 1'b0;
            burst_q <= 1'b0;
            wdog_q <= 1'b1;
        end else begin
            prev_below_q <= prev_below_d;
            sw_q <= sw_d;
            led_q <= led_d;
            led_cnt_q <= led_cnt_d;
            echo_q <= echo_d;
            burst_q <= burst_d;
            wdog_q <= wdog_d;
        end
    end

    assign echo_tx = echo_q;
    assign led = led_q;
    assign burst_drive = burst_q;
    assign watchdog_en = wdog_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_auto_start_tick: assert property ((state_q == MS_BURST && $past(state_q) == MS_IDLE &&
        mode_q == MODE_AUTO_SER) |-> $past(tick)) else $error("auto start w/o tick");
    a_frame_follows: assert property ((done && serial) |=> (fr_busy_q && fr_idx_q == 2'h0 &&
        fr_dist_q == $past(dist_q))) else $error("frame not started");
    a_frame_header: assert property ((fr_busy_q && fr_idx_q == 2'h0) |->
        tx_data == 8'hff) else $error("bad header");
    a_frame_sum: assert property ((fr_busy_q && fr_idx_q == 2'h3) |-> tx_data ==
        8'(8'hff + fr_dist_q[15:8] + fr_dist_q[7:0])) else $error("bad checksum");
    a_fail_zero: assert property ((state_q == MS_LISTEN && !echo_detect &&
        meas_cnt_q >= 32'(TIMEOUT_CYC - 1)) |=> done && dist_q == 16'h0)
        else $error("timeout not zero");
    a_blind_min: assert property ((done && dist_q != 16'h0) |-> dist_q >= MIN_MM)
        else $error("below blind minimum");
    a_cmd_toggle: assert property (cmd_ok |=> led != $past(led))
        else $error("led not toggled");
    a_watchdog_off: assert property ((taken_q && mode_q == MODE_LOWPWR) |=> !watchdog_en)
        else $error("watchdog on");
    a_switch_two: assert property ($rose(sw_q) |-> $past(prev_below_q) && $past(below))
        else $error("switch after one reading");
    a_burst_len: assert property ((state_q == MS_LISTEN && $past(state_q) == MS_BURST) |->
        $past(half_q) == 5'd15) else $error("burst length");
    a_timeout_bound: assert property (meas_cnt_q <= 32'(TIMEOUT_CYC))
        else $error("pulse beyond timeout");

endmodule

// ===== design/urm_pkg.sv
/*
 * Shared constants and types of the ultrasonic range output block.
 * Assumes a single 250 MHz clock; every cycle count below derives from it.
 */
package urm_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 250_000_000;
    localparam int AUTO_PERIOD_MS = 100;
    localparam int SLOW_PERIOD_MS = 200;
    localparam int TIMEOUT_MS = 40;
    localparam int LED_PERIOD_MS = 100;
    localparam int TRIG_MIN_US = 10;
    localparam int BURST_HZ = 40_000;
    localparam int BAUD_BPS = 9600;
    localparam int SOUND_MPS = 348;

    localparam int AUTO_PERIOD_CYC = (CLK_HZ / 1000) * AUTO_PERIOD_MS;
    localparam int SLOW_PERIOD_CYC = (CLK_HZ / 1000) * SLOW_PERIOD_MS;
    localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
    localparam int LED_HALF_CYC = (CLK_HZ / 1000) * LED_PERIOD_MS / 2;
    // Least time: integer division truncates, nothing is added to round up
    localparam int TRIG_MIN_CYC = (CLK_HZ / 1_000_000 * TRIG_MIN_US + 0);
    localparam int BURST_HALF_CYC = CLK_HZ / (2 * BURST_HZ);
    localparam int BIT_CYC = CLK_HZ / BAUD_BPS;
    // Round trip cycles per millimetre of distance
    localparam int CYC_PER_MM = (2 * CLK_HZ) / (SOUND_MPS * 1000);

    // ------------------------------------------------------------
    // Measurement and frame
    // ------------------------------------------------------------
    localparam int BURST_CYCLES = 8;
    localparam int UART_DATA_BITS = 8;
    localparam int DIST_W = 16;
    localparam logic [15:0] MIN_MM = 16'h00d2;
    localparam logic [15:0] THRESH_MM = 16'h05dc;
    localparam logic [7:0] FRAME_HEADER = 8'hff;
    localparam logic [7:0] CMD_MEASURE = 8'h55;
    localparam logic [1:0] FRAME_LAST = 2'h3;

    // ------------------------------------------------------------
    // Modes and states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_TRIG = 3'h0,
        MODE_AUTO_SER = 3'h1,
        MODE_POLL_SER = 3'h2,
        MODE_AUTO_PW = 3'h3,
        MODE_LOWPWR = 3'h4,
        MODE_SWITCH = 3'h5
    } urm_mode_t;

    typedef enum logic [3:0] {
        MS_IDLE = 4'h1,
        MS_BURST = 4'h2,
        MS_LISTEN = 4'h4,
        MS_REPORT = 4'h8
    } urm_meas_t;

endpackage

// ===== design/urm_uart.sv
/*
 * 8N1 serial transmitter and receiver for the range block.
 * Assumes rxd is synchronous to clk and idles high.
 */
`timescale 1ns/1ps
module urm_uart #(
    parameter int BIT_CYC = urm_pkg::BIT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Transmit side
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    output logic txd,
    // Receive side
    input wire logic rxd,
    output logic rx_valid,
    output logic [7:0] rx_data
);
    import urm_pkg::*;

    logic [31:0] tx_cnt_q, tx_cnt_d;
    logic [3:0] tx_bit_q, tx_bit_d;
    logic [9:0] tx_sh_q, tx_sh_d;
    logic tx_busy_q, tx_busy_d, txd_q, txd_d;
    logic [31:0] rx_cnt_q, rx_cnt_d;
    logic [3:0] rx_bit_q, rx_bit_d;
    logic [7:0] rx_sh_q, rx_sh_d, rx_data_q, rx_data_d;
    logic rx_busy_q, rx_busy_d, rx_valid_q, rx_valid_d;

    assign tx_ready = !tx_busy_q;
    assign txd = txd_q;
    assign rx_valid = rx_valid_q;
    assign rx_data = rx_data_q;

    // ------------------------------------------------------------
    // Transmitter: start bit, 8 data bits LSB first, stop bit
    // ------------------------------------------------------------
    always_comb begin
        tx_cnt_d = tx_cnt_q;
        tx_bit_d = tx_bit_q;
        tx_sh_d = tx_sh_q;
        tx_busy_d = tx_busy_q;
        if (!tx_busy_q) begin
            if (tx_valid) begin
                tx_sh_d = {1'b1, tx_data, 1'b0};
                tx_busy_d = 1'b1;
                tx_bit_d = 4'h0;
                tx_cnt_d = 32'h0;
            end
        end else if (tx_cnt_q == 32'(BIT_CYC - 1)) begin
            tx_cnt_d = 32'h0;
            if (tx_bit_q == 4'(UART_DATA_BITS + 1)) begin
                tx_busy_d = 1'b0;
            end else begin
                tx_bit_d = tx_bit_q + 4'h1;
                tx_sh_d = {1'b1, tx_sh_q[9:1]};
            end
        end else begin
            tx_cnt_d = tx_cnt_q + 32'h1;
        end
        txd_d = tx_busy_d ? tx_sh_d[0] : 1'b1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_cnt_q <= 32'h0;
            tx_bit_q <= 4'h0;
            tx_sh_q <= 10'h3ff;
            tx_busy_q <= 1'b0;
            txd_q <= 1'b1;
        end else begin
            tx_cnt_q <= tx_cnt_d;
            tx_bit_q <= tx_bit_d;
            tx_sh_q <= tx_sh_d;
            tx_busy_q <= tx_busy_d;
            txd_q <= txd_d;
        end
    end

    // ------------------------------------------------------------
    // Receiver: samples mid-bit, drops bytes with a bad stop bit
    // ------------------------------------------------------------
    always_comb begin
        rx_cnt_d = rx_cnt_q;
        rx_bit_d = rx_bit_q;
        rx_sh_d = rx_sh_q;
        rx_busy_d = rx_busy_q;
        rx_data_d = rx_data_q;
        rx_valid_d = 1'b0;
        if (!rx_busy_q) begin
            if (!rxd) begin
                rx_busy_d = 1'b1;
                rx_cnt_d = 32'h0;
                rx_bit_d = 4'h0;
            end
        end else if (rx_cnt_q == ((rx_bit_q == 4'h0) ? 32'(BIT_CYC / 2 - 1)
                                                      : 32'(BIT_CYC - 1))) begin
            rx_cnt_d = 32'h0;
            if (rx_bit_q == 4'h0) begin
                // False start on a glitch
                rx_busy_d = !rxd;
                rx_bit_d = 4'h1;
            end else if (rx_bit_q == 4'(UART_DATA_BITS + 1)) begin
                rx_busy_d = 1'b0;
                if (rxd) begin
                    rx_valid_d = 1'b1;
                    rx_data_d = rx_sh_q;
                end
            end else begin
                rx_sh_d = {rxd, rx_sh_q[7:1]};
                rx_bit_d = rx_bit_q + 4'h1;
            end
        end else begin
            rx_cnt_d = rx_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_cnt_q <= 32'h0;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 8'h00;
            rx_busy_q <= 1'b0;
            rx_data_q <= 8'h00;
            rx_valid_q <= 1'b0;
        end else begin
            rx_cnt_q <= rx_cnt_d;
            rx_bit_q <= rx_bit_d;
            rx_sh_q <= rx_sh_d;
            rx_busy_q <= rx_busy_d;
            rx_data_q <= rx_data_d;
            rx_valid_q <= rx_valid_d;
        end
    end

endmodule

// ===== tb/urm_host_model.sv
/* Host and analog front-end model for the range block bench.
   Assumes an 8N1 line idling high and BIT_CYC clocks per bit. */
`timescale 1ns/1ps
module urm_host_model #(
    parameter int BIT_CYC = 16
) (
    // Clock
    input wire logic clk,
    // Host pins
    input wire logic host_rxd,
    output logic host_txd,
    // Front end
    input wire logic burst_drive,
    output logic echo_detect
);
    int echo_delay = 0;
    initial host_txd = 1'b1;
    initial echo_detect = 1'b0;
    // Echo comes echo_delay clocks after the burst starts, none if zero
    always @(posedge burst_drive) begin
        if (echo_delay > 0) begin
            repeat (echo_delay) @(posedge clk);
            #1 echo_detect = 1'b1;
            repeat (4) @(posedge clk);
            #1 echo_detect = 1'b0;
        end
    end
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            #1 host_txd = f[i];
            repeat (BIT_CYC - 1) @(posedge clk);
        end
        #1;
    endtask
    // Trigger: brief low, then high for len clocks, then low again
    task automatic trig_pulse(input int len);
        #1 host_txd = 1'b0;
        repeat (4) @(posedge clk);
        #1 host_txd = 1'b1;
        repeat (len) @(posedge clk);
        #1 host_txd = 1'b0;
    endtask
    task automatic get_byte(input int lim, output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        b = 8'h00;
        while (host_rxd !== 1'b0 && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            b[i] = host_rxd;
        end
        repeat (BIT_CYC) @(posedge clk);
        ok = (n < lim) && (host_rxd === 1'b1);
    endtask
endmodule

// ===== tb/tb_urm_top.sv
/* Self-checking bench for urm_top in serial, switch and low-power trigger modes.
   Assumes shortened counts; the host model stands on the pins. */
`timescale 1ns/1ps
module tb_urm_top;
    localparam int AUTO = 2000;
    localparam int SLOW = 4000;
    localparam int BIT = 16;
    logic clk = 1'b0;
    logic rstn, auto_serial_strap, polled_serial_strap, trig_rx, echo_tx, led;
    logic [2:0] strap_code;
    logic burst_drive, echo_detect, watchdog_en;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    always #2 clk = ~clk;
    // Default distance scale: every short echo clamps to the blind-zone minimum
    urm_top #(.AUTO_CYC(AUTO), .SLOW_CYC(SLOW), .TIMEOUT_CYC(1500), .LED_HALF_CYC(500),
        .BIT_CYC(BIT), .BURST_HALF_CYC(4)) i_urm_top (.clk(clk),
        .rstn(rstn), .strap_code(strap_code), .auto_serial_strap(auto_serial_strap),
        .polled_serial_strap(polled_serial_strap), .trig_rx(trig_rx), .echo_tx(echo_tx),
        .led(led), .burst_drive(burst_drive), .echo_detect(echo_detect),
        .watchdog_en(watchdog_en));
    // Model default bit time equals BIT
    urm_host_model i_urm_host_model (.clk(clk), .host_rxd(echo_tx),
        .host_txd(trig_rx), .burst_drive(burst_drive), .echo_detect(echo_detect));
    task automatic give_verdict();
        if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 50000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic do_reset(input logic [2:0] code, input logic a, input logic p);
        rstn = 1'b0;
        strap_code = code;
        auto_serial_strap = a;
        polled_serial_strap = p;
        repeat (16) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic wait_start(input int lim, output int n);
        n = 0;
        while (burst_drive !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task automatic wait_led(output int n);
        logic v;
        v = led;
        n = 0;
        while (led === v && n < 2000) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task automatic get_frame(input logic [7:0] hi, input logic [7:0] lo);
        logic [7:0] b;
        logic [7:0] sum;
        logic ok;
        sum = 8'hff + hi + lo;
        i_urm_host_model.get_byte(3000, b, ok);
        check("header", {8'h00, b}, 16'h00ff);
        i_urm_host_model.get_byte(BIT, b, ok);
        check("dist high", {8'h00, b}, {8'h00, hi});
        i_urm_host_model.get_byte(BIT, b, ok);
        check("dist low", {8'h00, b}, {8'h00, lo});
        i_urm_host_model.get_byte(BIT, b, ok);
        check("checksum", {8'h00, b}, {8'h00, sum});
        check("gapless stop", {15'h0, ok}, 16'h0001);
    endtask
    task automatic scen_auto_serial();
        int n;
        do_reset(3'h0, 1'b1, 1'b0);
        i_urm_host_model.echo_delay = 100;
        wait_start(5000, n);
        repeat (100) @(posedge clk);
        #1;
        wait_start(5000, n);
        check("auto period", 16'(n + 100), 16'(AUTO));
        get_frame(8'h00, 8'hd2);
        wait_led(n);
        wait_led(n);
        check("led half period", 16'(n), 16'd500);
    endtask
    task automatic scen_polled();
        int n;
        logic l0;
        do_reset(3'h0, 1'b0, 1'b1);
        i_urm_host_model.echo_delay = 0;
        l0 = led;
        i_urm_host_model.send_byte(8'h12);
        wait_start(300, n);
        check("start on other byte", {15'h0, burst_drive}, 16'h0000);
        i_urm_host_model.send_byte(8'h55);
        wait_start(100, n);
        check("start on command", {15'h0, burst_drive}, 16'h0001);
        check("led first", {15'h0, led}, {15'h0, ~l0});
        get_frame(8'h00, 8'h00);
        i_urm_host_model.echo_delay = 100;
        i_urm_host_model.send_byte(8'h55);
        wait_start(100, n);
        get_frame(8'h00, 8'hd2);
        check("led second", {15'h0, led}, {15'h0, l0});
    endtask
    task automatic scen_switch();
        int n;
        do_reset(3'h5, 1'b0, 1'b0);
        check("watchdog on", {15'h0, watchdog_en}, 16'h0001);
        i_urm_host_model.echo_delay = 100;
        wait_start(5000, n);
        repeat (300) @(posedge clk);
        #1;
        check("switch after one", {15'h0, echo_tx}, 16'h0000);
        wait_start(5000, n);
        check("slow period", 16'(n + 300), 16'(SLOW));
        repeat (300) @(posedge clk);
        #1;
        check("switch after two", {15'h0, echo_tx}, 16'h0001);
        i_urm_host_model.echo_delay = 0;
        wait_start(5000, n);
        repeat (1700) @(posedge clk);
        #1;
        check("switch on no echo", {15'h0, echo_tx}, 16'h0000);
    endtask
    // Width of the next high pulse on the echo pin, in clocks
    task automatic pulse_width(output int w);
        int n;
        n = 0;
        w = 0;
        while (echo_tx !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1 n++;
        end
        while (echo_tx === 1'b1 && w < 3000) begin
            @(posedge clk);
            #1 w++;
        end
    endtask
    task automatic scen_lowpwr();
        int w;
        do_reset(3'h4, 1'b0, 1'b0);
        check("watchdog off", {15'h0, watchdog_en}, 16'h0000);
        i_urm_host_model.echo_delay = 100;
        i_urm_host_model.trig_pulse(2600);
        pulse_width(w);
        // Echo delay plus one clock of echo_detect sampling and one clock of echo_tx register lag
        check("echo width", 16'(w), 16'd102);
        i_urm_host_model.echo_delay = 0;
        i_urm_host_model.trig_pulse(2600);
        pulse_width(w);
        check("no echo width", 16'(w), 16'd1500);
    endtask
    initial begin
        scen_auto_serial();
        scen_polled();
        scen_switch();
        scen_lowpwr();
        give_verdict();
    end
endmodule
